// ---- core/bkc_core.sv ----
// backlash compensation core with avalon register slave
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`default_nettype none
module bkc_core #(
    parameter int W = 64,
    parameter int FILT_SHIFT = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // drive state
    input wire logic motor_powered,
    input wire logic overtravel,
    input wire logic [1:0] control_type,
    // reference side, one increment per cycle
    input wire logic signed [31:0] ref_increment,
    input wire logic signed [W-1:0] target_position,
    input wire logic signed [W-1:0] filtered_reference,
    input wire logic signed [W-1:0] unfiltered_reference_position,
    input wire logic signed [31:0] input_reference_speed,
    // feedback side
    input wire logic signed [W-1:0] shaft_position,
    input wire logic latch_strobe,
    // outputs
    output logic signed [W-1:0] command_reference_position,
    output logic signed [W-1:0] machine_feedback_position,
    output logic signed [W-1:0] position_error_value,
    output logic signed [31:0] offset_increment,
    output logic comp_active
);
    logic [31:0] ctrl_q;
    logic signed [31:0] amount_q;
    logic [15:0] tconst_q;
    logic [31:0] omsel_q;
    logic [3:0] monsel_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic signed [W-1:0] cmd_ref_q;
    logic signed [W-1:0] ref_cnt_q;
    logic signed [W-1:0] fb_q;
    logic signed [W-1:0] position_error_value_q;
    logic signed [W-1:0] latch_q;
    logic signed [W-1:0] prev_latch_q;
    logic signed [31:0] offset_q;
    logic signed [31:0] offset_tgt_q;
    logic last_dir_q;
    logic active_q;
    logic signed [31:0] offset_incr_q;
    logic signed [31:0] offset_pulses;
    logic signed [31:0] dir_pulses;
    logic enabled;
    logic move_dir;
    logic [3:0] div_sh;
    logic signed [31:0] step;
    logic signed [31:0] offset_d;
    logic signed [W-1:0] mon_val;

    // rounded division by ten, half away from zero
    function automatic logic signed [31:0] round_tenth(input logic signed [31:0] v);
        logic signed [31:0] a;
        a = v < 0 ? -v : v;
        a = (a + 32'sd5) / 32'sd10;
        return v < 0 ? -a : a;
    endfunction

    assign offset_pulses = round_tenth(amount_q);
    assign dir_pulses = ctrl_q[bkc_pkg::CTRL_DIR_BIT] == bkc_pkg::DIR_REV ? -offset_pulses : offset_pulses;
    assign div_sh = ctrl_q[bkc_pkg::CTRL_ROUND_DIV_POS+:4];

    assign enabled = motor_powered && !overtravel && control_type == bkc_pkg::CTL_POSITION;
    assign move_dir = ref_increment < 0 ? bkc_pkg::DIR_REV : bkc_pkg::DIR_FWD;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_dir_q <= bkc_pkg::DIR_FWD;
        end else if (ref_increment != 0) begin
            last_dir_q <= move_dir;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            offset_tgt_q <= '0;
            active_q <= 1'b0;
        end else if (!enabled) begin
            offset_tgt_q <= '0;
            active_q <= 1'b0;
        end else if (ref_increment != 0 && (move_dir != last_dir_q || !active_q)) begin
            active_q <= 1'b1;
            offset_tgt_q <= (move_dir == ctrl_q[bkc_pkg::CTRL_DIR_BIT]) ? dir_pulses : 32'sd0;
        end
    end

    always_comb begin
        step = (offset_tgt_q - offset_q) >>> div_sh;
        if (step == 0 && offset_tgt_q != offset_q) begin
            step = offset_tgt_q > offset_q ? 32'sd1 : -32'sd1;
        end
        if (!enabled) begin
            offset_d = 32'sd0;
        end else if (tconst_q == 16'h0000) begin
            offset_d = offset_tgt_q;
        end else begin
            offset_d = offset_q + step;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            offset_q <= '0;
            offset_incr_q <= '0;
        end else begin
            offset_q <= offset_d;
            offset_incr_q <= offset_d - offset_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_cnt_q <= '0;
            cmd_ref_q <= '0;
        end else begin
            ref_cnt_q <= ref_cnt_q + W'(ref_increment);
            cmd_ref_q <= enabled ? cmd_ref_q + W'(ref_increment) : shaft_position;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fb_q <= '0;
            position_error_value_q <= '0;
        end else begin
            fb_q <= shaft_position - W'(offset_q);
            position_error_value_q <= (cmd_ref_q + W'(offset_q)) - shaft_position;
        end
    end

    // latch capture, offset removed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_q <= '0;
            prev_latch_q <= '0;
        end else if (latch_strobe) begin
            latch_q <= shaft_position - W'(offset_q);
            prev_latch_q <= latch_q;
        end
    end

    // option monitor value
    function automatic logic [31:0] opt_mon(input logic [15:0] sel);
        case (sel)
            bkc_pkg::OM_POSITION_ERROR_VALUE_LO: opt_mon = position_error_value_q[31:0];
            bkc_pkg::OM_POSITION_ERROR_VALUE_HI: opt_mon = position_error_value_q[W-1:W-32];
            bkc_pkg::OM_ENC_LO: opt_mon = shaft_position[31:0];
            bkc_pkg::OM_ENC_HI: opt_mon = shaft_position[W-1:W-32];
            bkc_pkg::OM_FB_CNT: opt_mon = shaft_position[31:0];
            bkc_pkg::OM_SPEED: opt_mon = input_reference_speed;
            bkc_pkg::OM_POSITION_ERROR_VALUE_MON: opt_mon = position_error_value_q[31:0];
            bkc_pkg::OM_REF_CNT: opt_mon = ref_cnt_q[31:0];
            bkc_pkg::OM_PREV_LATCH: opt_mon = prev_latch_q[31:0];
            default: opt_mon = 32'h0000_0000;
        endcase
    endfunction

    always_comb begin
        case (monsel_q)
            bkc_pkg::MON_FILT_REF: mon_val = filtered_reference;
            bkc_pkg::MON_CMD_REF: mon_val = cmd_ref_q;
            bkc_pkg::MON_POSITION_ERROR_VALUE: mon_val = position_error_value_q;
            bkc_pkg::MON_FB: mon_val = fb_q;
            bkc_pkg::MON_LATCH: mon_val = latch_q;
            bkc_pkg::MON_UNFILT: mon_val = unfiltered_reference_position;
            bkc_pkg::MON_TARGET: mon_val = target_position;
            bkc_pkg::MON_OPT1: mon_val = W'(opt_mon(omsel_q[15:0]));
            bkc_pkg::MON_OPT2: mon_val = W'(opt_mon(omsel_q[31:16]));
            default: mon_val = '0;
        endcase
    end

    // bus: one wait cycle then answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= bkc_pkg::CTRL_RST;
            amount_q <= bkc_pkg::AMOUNT_RST;
            tconst_q <= bkc_pkg::TCONST_RST;
            omsel_q <= '0;
            monsel_q <= '0;
        end else if (avs_write && !wait_q) begin
            case (avs_address)
                bkc_pkg::REG_CTRL: ctrl_q <= avs_writedata;
                bkc_pkg::REG_AMOUNT: amount_q <= avs_writedata;
                bkc_pkg::REG_TCONST: tconst_q <= avs_writedata[15:0];
                bkc_pkg::REG_OMSEL: omsel_q <= avs_writedata;
                bkc_pkg::REG_MONSEL: monsel_q <= avs_writedata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (avs_read && wait_q) begin
            case (avs_address)
                bkc_pkg::REG_CTRL: rdata_q <= ctrl_q;
                bkc_pkg::REG_AMOUNT: rdata_q <= amount_q;
                bkc_pkg::REG_TCONST: rdata_q <= {16'h0000, tconst_q};
                bkc_pkg::REG_OMSEL: rdata_q <= omsel_q;
                bkc_pkg::REG_STATUS: rdata_q <= {31'h0, active_q};
                bkc_pkg::REG_MONSEL: rdata_q <= {28'h0, monsel_q};
                bkc_pkg::REG_MONLO: rdata_q <= mon_val[31:0];
                bkc_pkg::REG_MONHI: rdata_q <= mon_val[W-1:W-32];
                bkc_pkg::REG_OM1: rdata_q <= opt_mon(omsel_q[15:0]);
                bkc_pkg::REG_OM2: rdata_q <= opt_mon(omsel_q[31:16]);
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign command_reference_position = cmd_ref_q;
    assign machine_feedback_position = fb_q;
    assign position_error_value = position_error_value_q;
    assign offset_increment = offset_incr_q;
    assign comp_active = active_q;

    property p_power_off_clear;
        @(posedge clk) disable iff (sys_rst) !motor_powered |=> offset_q == 0;
    endproperty
    a_power_off_clear: assert property (p_power_off_clear) else $error("offset kept without power");

    property p_ot_clear;
        @(posedge clk) disable iff (sys_rst) overtravel |=> offset_tgt_q == 0;
    endproperty
    a_ot_clear: assert property (p_ot_clear) else $error("offset in overtravel");

    property p_ctl_clear;
        @(posedge clk) disable iff (sys_rst) control_type != bkc_pkg::CTL_POSITION |=> !active_q;
    endproperty
    a_ctl_clear: assert property (p_ctl_clear) else $error("active outside position control");

    // bypass reaches target in one cycle
    property p_bypass;
        @(posedge clk) disable iff (sys_rst) tconst_q == 16'h0000 && enabled |=> offset_q == $past(offset_tgt_q);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass filter lag");

    property p_fb;
        @(posedge clk) disable iff (sys_rst) 1'b1 |=> fb_q == $past(shaft_position) - W'($past(offset_q));
    endproperty
    a_fb: assert property (p_fb) else $error("feedback offset wrong");

    sequence s_rev_move;
        enabled && ref_increment != 0 && move_dir != ctrl_q[bkc_pkg::CTRL_DIR_BIT];
    endsequence
    property p_opposite;
        @(posedge clk) disable iff (sys_rst) s_rev_move |=> offset_tgt_q == 0;
    endproperty
    a_opposite: assert property (p_opposite) else $error("offset on opposite move");

    sequence s_comp_move;
        enabled && ref_increment != 0 && move_dir == ctrl_q[bkc_pkg::CTRL_DIR_BIT];
    endsequence
    property p_comp;
        @(posedge clk) disable iff (sys_rst) s_comp_move ##0 $stable(amount_q) |=> offset_tgt_q == $past(dir_pulses);
    endproperty
    a_comp: assert property (p_comp) else $error("offset missing on compensating move");

    property p_refcnt;
        @(posedge clk) disable iff (sys_rst) 1'b1 |=> ref_cnt_q == $past(ref_cnt_q) + W'($past(ref_increment));
    endproperty
    a_refcnt: assert property (p_refcnt) else $error("reference counter wrong");
endmodule // bkc_core
`default_nettype wire

// ---- include/bkc_pkg.sv ----
// package for the backlash compensation block
`default_nettype none
package bkc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_AMOUNT = 8'h04;
    localparam logic [7:0] REG_TCONST = 8'h08;
    localparam logic [7:0] REG_OMSEL = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MONSEL = 8'h14;
    localparam logic [7:0] REG_MONLO = 8'h18;
    localparam logic [7:0] REG_MONHI = 8'h1c;
    localparam logic [7:0] REG_OM1 = 8'h20;
    localparam logic [7:0] REG_OM2 = 8'h24;
    // control fields
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_ROUND_DIV_POS = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] AMOUNT_RST = 32'h0000_0000;
    localparam logic [15:0] TCONST_RST = 16'h0000;
    // direction codes
    localparam logic DIR_FWD = 1'b0;
    localparam logic DIR_REV = 1'b1;
    // main monitor codes
    localparam logic [3:0] MON_FILT_REF = 4'h0;
    localparam logic [3:0] MON_CMD_REF = 4'h1;
    localparam logic [3:0] MON_POSITION_ERROR_VALUE = 4'h2;
    localparam logic [3:0] MON_FB = 4'h3;
    localparam logic [3:0] MON_LATCH = 4'h4;
    localparam logic [3:0] MON_UNFILT = 4'h5;
    localparam logic [3:0] MON_TARGET = 4'h6;
    localparam logic [3:0] MON_OPT1 = 4'he;
    localparam logic [3:0] MON_OPT2 = 4'hf;
    // option monitor codes
    localparam logic [15:0] OM_POSITION_ERROR_VALUE_LO = 16'h0003;
    localparam logic [15:0] OM_POSITION_ERROR_VALUE_HI = 16'h0004;
    localparam logic [15:0] OM_ENC_LO = 16'h000a;
    localparam logic [15:0] OM_ENC_HI = 16'h000b;
    localparam logic [15:0] OM_RSV_C = 16'h000c;
    localparam logic [15:0] OM_RSV_D = 16'h000d;
    localparam logic [15:0] OM_SPEED = 16'h0017;
    localparam logic [15:0] OM_POSITION_ERROR_VALUE_MON = 16'h0018;
    localparam logic [15:0] OM_REF_CNT = 16'h001c;
    localparam logic [15:0] OM_FB_CNT = 16'h001d;
    localparam logic [15:0] OM_PREV_LATCH = 16'h0080;
    // control types
    localparam logic [1:0] CTL_POSITION = 2'h0;
    // one wait cycle before each bus answer
    localparam int BUS_WAIT = 1;
endpackage
`default_nettype wire

// ---- sim/bkc_plant.sv ----
// motor and encoder model: the shaft follows every pulse the drive emits while motor_powered is high
`default_nettype none
module bkc_plant (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // drive outputs
    input wire logic motor_powered,
    input wire logic signed [31:0] ref_increment,
    input wire logic signed [31:0] offset_increment,
    // encoder
    output logic signed [63:0] shaft_position
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shaft_position <= 64'sh0;
        end else if (motor_powered) begin
            shaft_position <= shaft_position + 64'(ref_increment) + 64'(offset_increment);
        end
    end
endmodule // bkc_plant
`default_nettype wire

// ---- sim/backlash_compensation_tb.sv ----
// self-checking bench for the backlash compensation core
`default_nettype none
module backlash_compensation_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic motor_powered, overtravel, latch_strobe, comp_active;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0] control_type;
    logic signed [31:0] ref_increment, input_reference_speed, offset_increment;
    logic signed [63:0] target_position, filtered_reference, unfiltered_reference_position, shaft_position;
    logic signed [63:0] command_reference_position, machine_feedback_position, position_error_value, pos;
    logic signed [63:0] lat, refsum;
    logic [31:0] expq[$];
    int fails = 0;
    int compares = 0;
    int seed = 70712;

    bkc_core dut (
        .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
        .avs_readdata, .avs_waitrequest, .motor_powered, .overtravel, .control_type, .ref_increment,
        .target_position, .filtered_reference, .unfiltered_reference_position, .input_reference_speed,
        .shaft_position, .latch_strobe, .command_reference_position, .machine_feedback_position,
        .position_error_value, .offset_increment, .comp_active
    );
    bkc_plant plant (
        .clk, .sys_rst, .motor_powered, .ref_increment, .offset_increment, .shaft_position
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t read %h expected %h", $time, g, e);
        end
    endtask

    // read answers are compared against the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (expq.size() == 0) begin
                fails++;
                $display("[ERR] %0t unexpected read answer", $time);
            end else begin
                chk32(expq.pop_front(), avs_readdata);
            end
        end
    end

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                fails++;
                $display("[ERR] %0t bus answer missing", $time);
                stop_test();
            end
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic mon(input logic [3:0] code, input logic [63:0] e);
        wr(bkc_pkg::REG_MONSEL, {28'h0, code});
        rd(bkc_pkg::REG_MONLO, e[31:0]);
        rd(bkc_pkg::REG_MONHI, e[63:32]);
    endtask

    task automatic om(input logic [15:0] sel, input logic [31:0] e);
        wr(bkc_pkg::REG_OMSEL, {sel, sel});
        rd(bkc_pkg::REG_OM1, e);
        rd(bkc_pkg::REG_OM2, e);
    endtask

    task automatic move(input int n, input int dir);
        int mag;
        repeat (n) begin
            @(posedge clk);
            mag = ($random(seed) & 31) + 1;
            ref_increment <= 32'(dir * mag);
            pos = pos + 64'(dir * mag);
            refsum = refsum + 64'(dir * mag);
        end
        @(posedge clk);
        ref_increment <= 32'sh0;
        repeat (20) @(posedge clk);
    endtask

    task automatic en();
        @(posedge clk);
        motor_powered <= 1'b1;
        overtravel <= 1'b0;
        control_type <= bkc_pkg::CTL_POSITION;
    endtask

    task automatic latch();
        @(posedge clk);
        latch_strobe <= 1'b1;
        @(posedge clk);
        latch_strobe <= 1'b0;
    endtask

    task automatic check_on(input logic signed [63:0] off);
        logic signed [63:0] s;
        s = pos + off;
        mon(bkc_pkg::MON_FB, pos);
        mon(bkc_pkg::MON_CMD_REF, pos);
        mon(bkc_pkg::MON_POSITION_ERROR_VALUE, 64'sh0);
        om(bkc_pkg::OM_ENC_LO, s[31:0]);
        mon(bkc_pkg::MON_OPT1, {32'h0, s[31:0]});
        om(bkc_pkg::OM_ENC_HI, s[63:32]);
        mon(bkc_pkg::MON_OPT2, {32'h0, s[63:32]});
        om(bkc_pkg::OM_FB_CNT, s[31:0]);
        om(bkc_pkg::OM_REF_CNT, refsum[31:0]);
        om(bkc_pkg::OM_POSITION_ERROR_VALUE_LO, 32'h0);
        om(bkc_pkg::OM_POSITION_ERROR_VALUE_HI, 32'h0);
        om(bkc_pkg::OM_POSITION_ERROR_VALUE_MON, 32'h0);
        rd(bkc_pkg::REG_STATUS, 32'h1);
        chk32(pos[31:0], machine_feedback_position[31:0]);
        chk32(pos[31:0], command_reference_position[31:0]);
        chk32(32'h0, position_error_value[31:0]);
        chk32(32'h1, {31'h0, comp_active});
        chk32(32'h0, offset_increment);
    endtask

    task automatic dis(input int c, input logic signed [63:0] off);
        @(posedge clk);
        if (c == 0) begin
            motor_powered <= 1'b0;
        end else if (c == 1) begin
            overtravel <= 1'b1;
        end else begin
            control_type <= 2'h1;
        end
        repeat (20) @(posedge clk);
        // powered cases drive the offset back out, unpowered keeps it in the shaft
        if (c == 0) begin
            pos = pos + off;
        end
        mon(bkc_pkg::MON_FB, pos);
        mon(bkc_pkg::MON_CMD_REF, pos);
        rd(bkc_pkg::REG_STATUS, 32'h0);
        $display("test disable %0d done", c);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        motor_powered = 1'b0;
        overtravel = 1'b0;
        control_type = bkc_pkg::CTL_POSITION;
        ref_increment = 32'sh0;
        latch_strobe = 1'b0;
        target_position = {$random(seed), $random(seed)};
        filtered_reference = {$random(seed), $random(seed)};
        unfiltered_reference_position = {$random(seed), $random(seed)};
        input_reference_speed = $random(seed);
        pos = 64'sh0;
        refsum = 64'sh0;
        lat = 64'sh0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(bkc_pkg::REG_CTRL, bkc_pkg::CTRL_RST);
        rd(bkc_pkg::REG_AMOUNT, bkc_pkg::AMOUNT_RST);
        rd(bkc_pkg::REG_TCONST, {16'h0, bkc_pkg::TCONST_RST});
        rd(8'h30, 32'h0);
        rd(bkc_pkg::REG_STATUS, 32'h0);
        mon(bkc_pkg::MON_FILT_REF, filtered_reference);
        mon(bkc_pkg::MON_UNFILT, unfiltered_reference_position);
        mon(bkc_pkg::MON_TARGET, target_position);
        om(bkc_pkg::OM_SPEED, input_reference_speed);
        om(bkc_pkg::OM_RSV_C, 32'h0);
        om(bkc_pkg::OM_RSV_D, 32'h0);
        $display("test reset and monitors done");
        wr(bkc_pkg::REG_CTRL, {31'h0, bkc_pkg::DIR_FWD});
        wr(bkc_pkg::REG_AMOUNT, 32'h68);
        wr(bkc_pkg::REG_TCONST, 32'h0);
        en();
        move(4, 1);
        check_on(64'sha);
        move(3, -1);
        check_on(64'sh0);
        move(2, 1);
        check_on(64'sha);
        latch();
        mon(bkc_pkg::MON_LATCH, pos);
        lat = pos;
        move(1, 1);
        latch();
        mon(bkc_pkg::MON_LATCH, pos);
        om(bkc_pkg::OM_PREV_LATCH, lat[31:0]);
        $display("test forward done");
        for (int c = 0; c < 3; c++) begin
            dis(c, 64'sha);
            en();
            move(2, 1);
            check_on(64'sha);
        end
        dis(0, 64'sha);
        wr(bkc_pkg::REG_CTRL, {31'h0, bkc_pkg::DIR_REV});
        wr(bkc_pkg::REG_AMOUNT, 32'h60);
        en();
        move(3, -1);
        check_on(-64'sha);
        move(2, 1);
        check_on(64'sh0);
        $display("test reverse done");
        dis(0, 64'sh0);
        wr(bkc_pkg::REG_CTRL, 32'h0000_0200);
        wr(bkc_pkg::REG_TCONST, 32'h0000_0001);
        en();
        move(2, 1);
        check_on(64'sha);
        $display("test lag filter done");
        stop_test();
    end
endmodule // backlash_compensation_tb
`default_nettype wire
